// ==== cmp_pkg.sv ====
// Purpose: constants for the comparator event control block
// Assumes: 32-bit axi4-lite register bus, 20 MHz aclk
// Notes:   offsets are byte addresses
//
// Summary of operation
// RULE_01: the digital result follows the comparison of the minus input against the plus input.
// RULE_02: the current result is always readable at bit 5 of the control register.
// RULE_03: output select 1,0 routes the result to the result pin.
// RULE_04: output select 1,1 runs the cell as an amplifier with the schmitt stage off.
// RULE_05: in amplifier mode the mask, wake and flag bits are ignored and no interrupt or wake-up occurs.
// RULE_06: any change of the result in either direction sets the event flag.
// RULE_07: the interrupt reaches the core only while the mask bit and global enable are both set.
// RULE_08: the event flag stays set until software clears it.
// RULE_09: with wake enable set the comparator and its interrupt logic stay active in sleep.
// RULE_10: with wake enable set a change during sleep wakes the core.
// RULE_11: a wake-up with mask set and global interrupts off resumes after the sleep instruction.
// RULE_12: with mask set and global interrupts on an event vectors to 0x00F.
// RULE_13: software should turn the comparator off before sleep unless it is a wake source.
// RULE_14: the result is synchronised and a change found by comparing successive samples.
// RULE_15: reset clears the control register, event flag, mask bit and wake enable.
package cmp_pkg;
  localparam logic [7:0] CTL_OFFSET     = 8'h08;
  localparam logic [7:0] EVT_OFFSET     = 8'h0C;
  localparam logic [7:0] IRQ_STS_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_MSK_OFFSET = 8'h14;
  localparam int RESULT_POS  = 5;
  localparam int SEL_HI_POS  = 4;
  localparam int SEL_LO_POS  = 3;
  localparam int FLAG_POS    = 4;
  localparam int WAKE_POS    = 2;
  localparam int MASK_POS    = 0;
  localparam int GIE_POS     = 1;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'h1F;
  localparam logic [1:0] SEL_PIN   = 2'h2;
  localparam logic [1:0] SEL_OPAMP = 2'h3;
  localparam logic [11:0] CMP_VECTOR = 12'h00F;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== cmp_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: async level input
// Notes:   first stage read only by second
`timescale 1ns/1ps
module cmp_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  logic s1_reg, s2_reg, s3_reg, out_reg;
  logic s1_next, s2_next, s3_next, out_next;
  always_comb begin
    s1_next  = din;
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    out_next = (s2_reg == s3_reg) ? s3_reg : out_reg; // RULE_14
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      out_reg <= out_next;
    end
  end
  assign dout = out_reg;
endmodule // cmp_sync

// ==== cmp_event_ctl.sv ====
// Purpose: comparator event control with axi4-lite registers
// Assumes: analog cell gives raw compare level cmp_raw (1 when minus below plus)
// Notes:   one write and one read in flight at a time
`timescale 1ns/1ps
module cmp_event_ctl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cmp_raw,
  input  wire logic        sleeping,
  output logic             result_pin,
  output logic             result_pin_oe,
  output logic             opamp_mode,
  output logic             schmitt_en,
  output logic             cmp_active,
  output logic             core_irq,
  output logic             wake_req,
  output logic             vector_req,
  output logic [11:0]      vector_addr,
  output logic             irq
);
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_DATA = 3'b010,
    WR_RESP = 3'b100
  } wr_state_type;

  wr_state_type wr_state_reg, wr_state_next;
  logic [7:0]  ctl_reg, ctl_next;
  logic [7:0]  evt_reg, evt_next;
  logic [1:0]  sts_reg, sts_next;
  logic [1:0]  msk_reg, msk_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic        aw_got_reg, aw_got_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        w_got_reg, w_got_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        prev_reg, prev_next;
  logic        pin_reg, pin_next, oe_reg, oe_next, op_reg, op_next, sch_reg, sch_next;
  logic        act_reg, act_next, cirq_reg, cirq_next, wake_reg, wake_next;
  logic        vreq_reg, vreq_next, irq_reg, irq_next;
  logic        cmp_sync_lvl;
  logic        change, op_now, do_write, flag_clr, sts_rd;
  logic        awr_reg, wr_reg, bv_reg, arr_reg;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == cmp_pkg::CTL_OFFSET) || (a == cmp_pkg::EVT_OFFSET) ||
             (a == cmp_pkg::IRQ_STS_OFFSET) || (a == cmp_pkg::IRQ_MSK_OFFSET);
  endfunction

  cmp_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (cmp_raw), // RULE_01
    .dout    (cmp_sync_lvl)
  );

  // write channel: address and data taken in any order, response after both
  always_comb begin
    wr_state_next = wr_state_reg;
    awaddr_next   = awaddr_reg;
    aw_got_next   = aw_got_reg;
    wdata_next    = wdata_reg;
    w_got_next    = w_got_reg;
    bresp_next    = bresp_reg;
    do_write      = 1'b0;
    case (wr_state_reg)
      WR_IDLE, WR_DATA: begin
        if (s_axi_awvalid && awr_reg) begin
          awaddr_next = s_axi_awaddr;
          aw_got_next = 1'b1;
        end
        if (s_axi_wvalid && wr_reg) begin
          wdata_next = s_axi_wdata;
          w_got_next = 1'b1;
        end
        wr_state_next = (aw_got_next || w_got_next) ? WR_DATA : WR_IDLE;
        if (aw_got_reg && w_got_reg) begin
          do_write      = 1'b1;
          bresp_next    = mapped(awaddr_reg) ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_SLVERR;
          wr_state_next = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          aw_got_next   = 1'b0;
          w_got_next    = 1'b0;
          wr_state_next = WR_IDLE;
        end
      end
      default: wr_state_next = WR_IDLE;
    endcase
  end

  // control, event, interrupt and output logic
  always_comb begin
    ctl_next = ctl_reg;
    evt_next = evt_reg;
    msk_next = msk_reg;
    flag_clr = 1'b0;
    // byte strobes ignored: every register is a full-word write
    if (do_write) begin
      case (awaddr_reg)
        cmp_pkg::CTL_OFFSET: ctl_next[4:0] = wdata_reg[4:0] & cmp_pkg::CTL_WMASK[4:0];
        cmp_pkg::EVT_OFFSET: begin
          evt_next[cmp_pkg::WAKE_POS] = wdata_reg[cmp_pkg::WAKE_POS]; // RULE_09
          evt_next[cmp_pkg::MASK_POS] = wdata_reg[cmp_pkg::MASK_POS];
          evt_next[cmp_pkg::GIE_POS]  = wdata_reg[cmp_pkg::GIE_POS];
          flag_clr = !wdata_reg[cmp_pkg::FLAG_POS]; // RULE_08
        end
        cmp_pkg::IRQ_MSK_OFFSET: msk_next = wdata_reg[1:0];
        default: ;
      endcase
    end
    ctl_next[7:6] = 2'h0;
    ctl_next[cmp_pkg::RESULT_POS] = cmp_sync_lvl; // RULE_02
    op_now = (ctl_reg[4:3] == cmp_pkg::SEL_OPAMP);
    change = (cmp_sync_lvl != prev_reg) && !op_now; // RULE_06 RULE_14 RULE_05
    prev_next = cmp_sync_lvl;
    evt_next[7:5] = 3'h0;
    if (flag_clr)
      evt_next[cmp_pkg::FLAG_POS] = 1'b0;
    if (change)
      evt_next[cmp_pkg::FLAG_POS] = 1'b1; // RULE_06
    // status: bit0 event, bit1 wake; read clears, set wins
    sts_next = sts_reg & ~(sts_rd ? 2'h3 : 2'h0);
    if (change)
      sts_next[0] = 1'b1;
    if (change && sleeping && evt_reg[cmp_pkg::WAKE_POS])
      sts_next[1] = 1'b1;
    irq_next  = |(sts_next & msk_next);
    pin_next  = (ctl_reg[4:3] == cmp_pkg::SEL_PIN) && cmp_sync_lvl; // RULE_03
    oe_next   = (ctl_reg[4:3] == cmp_pkg::SEL_PIN); // RULE_03
    op_next   = op_now; // RULE_04
    sch_next  = !op_now; // RULE_04
    act_next  = !sleeping || (evt_reg[cmp_pkg::WAKE_POS] && !op_now); // RULE_09
    cirq_next = !op_now && evt_next[cmp_pkg::FLAG_POS] && evt_reg[cmp_pkg::MASK_POS]
                && evt_reg[cmp_pkg::GIE_POS]; // RULE_07 RULE_05
    wake_next = !op_now && sleeping && evt_reg[cmp_pkg::WAKE_POS] && change; // RULE_10 RULE_11
    vreq_next = cirq_next; // RULE_12
  end

  // read channel: one cycle answer, held until rready
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    sts_rd      = 1'b0;
    if (rvalid_reg) begin
      if (s_axi_rready)
        rvalid_next = 1'b0;
    end else if (s_axi_arvalid && arr_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = mapped(s_axi_araddr) ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        cmp_pkg::CTL_OFFSET:     rdata_next = {24'h0, ctl_reg}; // RULE_02
        cmp_pkg::EVT_OFFSET:     rdata_next = {24'h0, evt_reg};
        cmp_pkg::IRQ_STS_OFFSET: begin
          rdata_next = {30'h0, sts_reg};
          sts_rd     = 1'b1;
        end
        cmp_pkg::IRQ_MSK_OFFSET: rdata_next = {30'h0, msk_reg};
        default:                 rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin // RULE_15
      wr_state_reg <= WR_IDLE;
      ctl_reg      <= cmp_pkg::CTL_RESET;
      evt_reg      <= 8'h00;
      sts_reg      <= 2'h0;
      msk_reg      <= 2'h0;
      awaddr_reg   <= 8'h00;
      aw_got_reg   <= 1'b0;
      wdata_reg    <= 32'h0;
      w_got_reg    <= 1'b0;
      bresp_reg    <= 2'h0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h0;
      rresp_reg    <= 2'h0;
      prev_reg     <= 1'b0;
      pin_reg      <= 1'b0;
      oe_reg       <= 1'b0;
      op_reg       <= 1'b0;
      sch_reg      <= 1'b1;
      act_reg      <= 1'b1;
      cirq_reg     <= 1'b0;
      wake_reg     <= 1'b0;
      vreq_reg     <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      wr_state_reg <= wr_state_next;
      ctl_reg      <= ctl_next;
      evt_reg      <= evt_next;
      sts_reg      <= sts_next;
      msk_reg      <= msk_next;
      awaddr_reg   <= awaddr_next;
      aw_got_reg   <= aw_got_next;
      wdata_reg    <= wdata_next;
      w_got_reg    <= w_got_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      prev_reg     <= prev_next;
      pin_reg      <= pin_next;
      oe_reg       <= oe_next;
      op_reg       <= op_next;
      sch_reg      <= sch_next;
      act_reg      <= act_next;
      cirq_reg     <= cirq_next;
      wake_reg     <= wake_next;
      vreq_reg     <= vreq_next;
      irq_reg      <= irq_next;
    end
  end

  // ready flags are registered so they come straight from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_reg <= 1'b0;
      wr_reg  <= 1'b0;
      bv_reg  <= 1'b0;
      arr_reg <= 1'b0;
    end else begin
      awr_reg <= (wr_state_next != WR_RESP) && !aw_got_next;
      wr_reg  <= (wr_state_next != WR_RESP) && !w_got_next;
      bv_reg  <= (wr_state_next == WR_RESP);
      arr_reg <= !rvalid_next;
    end
  end

  assign s_axi_awready = awr_reg;
  assign s_axi_wready  = wr_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign result_pin    = pin_reg;
  assign result_pin_oe = oe_reg;
  assign opamp_mode    = op_reg;
  assign schmitt_en    = sch_reg;
  assign cmp_active    = act_reg;
  assign core_irq      = cirq_reg;
  assign wake_req      = wake_reg;
  assign vector_req    = vreq_reg;
  assign vector_addr   = cmp_pkg::CMP_VECTOR; // RULE_12
  assign irq           = irq_reg;

  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn) change |=> evt_reg[cmp_pkg::FLAG_POS];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on change"); // RULE_06
  property p_flag_hold;
    @(posedge aclk) disable iff (!aresetn)
      evt_reg[cmp_pkg::FLAG_POS] && !flag_clr |=> evt_reg[cmp_pkg::FLAG_POS];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware"); // RULE_08
  property p_status;
    @(posedge aclk) disable iff (!aresetn) 1 |=> ctl_reg[cmp_pkg::RESULT_POS] == $past(cmp_sync_lvl);
  endproperty
  a_status: assert property (p_status) else $error("status bit stale"); // RULE_02
  property p_pin;
    @(posedge aclk) disable iff (!aresetn)
      ctl_reg[4:3] != cmp_pkg::SEL_PIN |=> !result_pin_oe && !result_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("pin driven outside pin mode"); // RULE_03
  property p_opamp;
    @(posedge aclk) disable iff (!aresetn)
      op_now |=> !core_irq && !wake_req && !schmitt_en;
  endproperty
  a_opamp: assert property (p_opamp) else $error("event in amplifier mode"); // RULE_04 RULE_05
  property p_gate;
    @(posedge aclk) disable iff (!aresetn)
      !(evt_reg[cmp_pkg::MASK_POS] && evt_reg[cmp_pkg::GIE_POS]) |=> !core_irq;
  endproperty
  a_gate: assert property (p_gate) else $error("irq without enables"); // RULE_07
  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
      change && sleeping && evt_reg[cmp_pkg::WAKE_POS] |=> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("missed wake-up"); // RULE_10
  property p_sync;
    @(posedge aclk) disable iff (!aresetn)
      $changed(cmp_sync_lvl) |=> prev_reg == $past(cmp_sync_lvl);
  endproperty
  a_sync: assert property (p_sync) else $error("previous sample wrong"); // RULE_14
  c_change: cover property (@(posedge aclk) disable iff (!aresetn) change);
  c_wake: cover property (@(posedge aclk) disable iff (!aresetn) wake_req);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) core_irq ##1 irq);
endmodule // cmp_event_ctl

// ==== cmp_cell_model.sv ====
// Purpose: behavioural analog comparator cell facing cmp_event_ctl
// Assumes: input levels given as 8-bit codes, settle delay in ns
// Notes:   output freezes while the cell is powered down
`timescale 1ns/1ps
module cmp_cell_model #(
  parameter int SETTLE_NS = 120
) (
  input  wire logic [7:0] vminus,
  input  wire logic [7:0] vplus,
  input  wire logic       cmp_active,
  output logic            cmp_raw
);
  // a slow settle keeps the edge away from aclk so the synchroniser is exercised
  initial begin
    cmp_raw = 1'b0;
    forever begin
      @(vminus, vplus, cmp_active);
      if (cmp_active) begin
        cmp_raw <= #(SETTLE_NS) (vminus < vplus);
      end
    end
  end
endmodule // cmp_cell_model

// ==== testbench.sv ====
// Purpose: self-checking bench for cmp_event_ctl
// Assumes: 20 MHz aclk, axi4-lite master tasks, cell model drives cmp_raw
// Notes:   bus handshake waits are unbounded; watchdog ends a hang
`timescale 1ns/1ps
module testbench;
  logic        aclk, aresetn, sleeping, cmp_raw;
  logic [7:0]  awaddr, araddr, vminus, vplus;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        result_pin, result_pin_oe, opamp_mode, schmitt_en, cmp_active;
  logic        core_irq, wake_req, vector_req, irq;
  logic [11:0] vector_addr;
  int          n_errors, num_checks, wake_cnt;

  cmp_event_ctl cmp_event_ctl_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_raw(cmp_raw),
    .sleeping(sleeping), .result_pin(result_pin), .result_pin_oe(result_pin_oe),
    .opamp_mode(opamp_mode), .schmitt_en(schmitt_en), .cmp_active(cmp_active),
    .core_irq(core_irq), .wake_req(wake_req), .vector_req(vector_req),
    .vector_addr(vector_addr), .irq(irq));

  cmp_cell_model cmp_cell_model_i (
    .vminus(vminus), .vplus(vplus), .cmp_active(cmp_active), .cmp_raw(cmp_raw));

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", cmp_pkg::RESP_OKAY, bresp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", cmp_pkg::RESP_OKAY, r);
  endtask

  // waits long enough for cell settle, synchroniser, flag and irq registers
  task automatic setcmp(input logic v);
    @(posedge aclk);
    vplus <= v ? 8'hC8 : 8'h32;
    wake_cnt = 0;
    repeat (14) begin
      @(posedge aclk);
      if (wake_req === 1'b1) wake_cnt++;
    end
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    tick(4);
    aresetn <= 1'b1;
    tick(2);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    tick(5000);
    n_errors++;
    wrap_up();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sleeping} = '0;
    {awaddr, araddr, wdata, n_errors, num_checks} = '0;
    vminus = 8'h64;
    vplus = 8'h32;
    tick(4);
    aresetn <= 1'b1;
    tick(2);
    rdchk("ctl reset", cmp_pkg::CTL_OFFSET, 32'h0);
    rdchk("evt reset", cmp_pkg::EVT_OFFSET, 32'h0);
    rdchk("sts reset", cmp_pkg::IRQ_STS_OFFSET, 32'h0);
    rdchk("msk reset", cmp_pkg::IRQ_MSK_OFFSET, 32'h0);
    chk("schmitt_en", 1, schmitt_en);
    chk("cmp_active", 1, cmp_active);
    rd(8'h20, d, r);
    chk("unmapped rresp", cmp_pkg::RESP_SLVERR, r);
    chk("unmapped rdata", 0, d);
    $display("test reset done");
    wr(cmp_pkg::CTL_OFFSET, 32'hF5);
    rdchk("ctl ro bits", cmp_pkg::CTL_OFFSET, 32'h15);
    tick(3);
    chk("pin oe", 1, result_pin_oe);
    chk("pin low", 0, result_pin);
    setcmp(1'b1);
    rdchk("ctl result", cmp_pkg::CTL_OFFSET, 32'h35);
    chk("pin high", 1, result_pin);
    rdchk("flag rise", cmp_pkg::EVT_OFFSET, 32'h10);
    $display("test routing done");
    wr(cmp_pkg::EVT_OFFSET, 32'h10);
    rdchk("flag kept", cmp_pkg::EVT_OFFSET, 32'h10);
    wr(cmp_pkg::EVT_OFFSET, 32'h00);
    rdchk("flag clear", cmp_pkg::EVT_OFFSET, 32'h00);
    setcmp(1'b0);
    rdchk("flag fall", cmp_pkg::EVT_OFFSET, 32'h10);
    $display("test flag done");
    wr(cmp_pkg::EVT_OFFSET, 32'h11);
    tick(3);
    chk("irq no gie", 0, core_irq);
    wr(cmp_pkg::EVT_OFFSET, 32'h13);
    tick(3);
    chk("irq gie", 1, core_irq);
    chk("vector_req", 1, vector_req);
    chk("vector_addr", 12'h00F, vector_addr);
    wr(cmp_pkg::EVT_OFFSET, 32'h03);
    tick(3);
    chk("irq cleared", 0, core_irq);
    $display("test core irq done");
    rd(cmp_pkg::IRQ_STS_OFFSET, d, r);
    wr(cmp_pkg::IRQ_MSK_OFFSET, 32'h01);
    chk("irq idle", 0, irq);
    setcmp(1'b1);
    chk("irq set", 1, irq);
    rdchk("sts", cmp_pkg::IRQ_STS_OFFSET, 32'h01);
    tick(2);
    chk("irq read clear", 0, irq);
    rdchk("sts empty", cmp_pkg::IRQ_STS_OFFSET, 32'h00);
    $display("test status done");
    wr(cmp_pkg::EVT_OFFSET, 32'h01);
    sleeping <= 1'b1;
    tick(3);
    chk("off in sleep", 0, cmp_active);
    wr(cmp_pkg::EVT_OFFSET, 32'h05);
    tick(3);
    chk("on in sleep", 1, cmp_active);
    setcmp(1'b0);
    chk("wake pulses", 1, wake_cnt);
    chk("no vector", 0, vector_req);
    rdchk("flag sleep", cmp_pkg::EVT_OFFSET, 32'h15);
    sleeping <= 1'b0;
    $display("test wake done");
    wr(cmp_pkg::EVT_OFFSET, 32'h17);
    wr(cmp_pkg::CTL_OFFSET, 32'h18);
    tick(3);
    chk("opamp", 1, opamp_mode);
    chk("schmitt off", 0, schmitt_en);
    chk("amp pin oe", 0, result_pin_oe);
    chk("amp irq", 0, core_irq);
    wr(cmp_pkg::EVT_OFFSET, 32'h07);
    setcmp(1'b1);
    rdchk("amp flag", cmp_pkg::EVT_OFFSET, 32'h07);
    chk("amp irq2", 0, core_irq);
    // sleep starts after the cell has launched its edge, so the change does reach the block
    fork
      setcmp(1'b0);
      begin
        tick(2);
        sleeping <= 1'b1;
      end
    join
    chk("amp wake", 0, wake_cnt);
    chk("amp asleep", 0, cmp_active);
    sleeping <= 1'b0;
    $display("test amplifier done");
    do_reset();
    rdchk("ctl rst2", cmp_pkg::CTL_OFFSET, 32'h0);
    rdchk("evt rst2", cmp_pkg::EVT_OFFSET, 32'h0);
    chk("opamp rst2", 0, opamp_mode);
    $display("test reset again done");
    wrap_up();
  end
endmodule // testbench
